/* File: hdl/spx_expander.sv */
// sixteen-pin io expander core: link, register file, pins and interrupt

module spx_expander (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register bus
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // serial link
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  output logic             spi_so,
  output logic             spi_so_oe_n,
  // reset pin
  input  wire logic        pin_reset_n,
  // port pins
  input  wire logic [15:0] port_pins_i,
  output logic [15:0]      port_pins_o,
  output logic [15:0]      port_pins_oe_n,
  output logic [15:0]      port_pins_pullup_en,
  // interrupt pin
  output logic             irq_n_o,
  output logic             irq_n_oe_n
);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [19:0] sync1_q;
  logic [19:0] sync2_q;
  logic [15:0] pins_s;
  logic        si_s;
  logic        sclk_s;
  logic        csn_s;
  logic        prst_n_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= spx_pkg::SYNC_RST;
      sync2_q <= spx_pkg::SYNC_RST;
    end else if (ce) begin
      sync1_q <= {pin_reset_n, spi_cs_n, spi_sclk, spi_si, port_pins_i};
      sync2_q <= sync1_q;
    end
  end

  assign pins_s   = sync2_q[15:0];
  assign si_s     = sync2_q[16];
  assign sclk_s   = sync2_q[17];
  assign csn_s    = sync2_q[18];
  assign prst_n_s = sync2_q[19];

  // ----------------------------------------------------------------
  // reset pin filter
  // ----------------------------------------------------------------
  // a glitch shorter than the limit never resets the part
  logic [3:0] rlow_q;
  logic       sreset;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rlow_q <= 4'h0;
    end else if (ce) begin
      if (prst_n_s) begin
        rlow_q <= 4'h0;
      end else if (rlow_q != spx_pkg::RST_LOW_CNT) begin
        rlow_q <= rlow_q + 4'h1;
      end
    end
  end

  assign sreset = (rlow_q == spx_pkg::RST_LOW_CNT);

  // ----------------------------------------------------------------
  // state and aliases
  // ----------------------------------------------------------------
  logic [spx_pkg::NCFG-1:0][15:0] cfg_q;
  logic [15:0] pend_q;
  logic [15:0] base_q;
  logic [15:0] prev_q;
  logic [15:0] out_v;
  logic [15:0] dir_v;
  logic [15:0] tri_v;
  logic [15:0] pull_v;
  logic [15:0] pol_v;
  logic [15:0] ien_v;
  logic [15:0] rise_en_v;
  logic [15:0] fall_en_v;
  logic [15:0] mask_v;
  logic [15:0] lvl;

  assign out_v     = cfg_q[spx_pkg::CFG_OUT];
  assign dir_v     = cfg_q[spx_pkg::CFG_DIR];
  assign tri_v     = cfg_q[spx_pkg::CFG_TRI];
  assign pull_v    = cfg_q[spx_pkg::CFG_PULL];
  assign pol_v     = cfg_q[spx_pkg::CFG_POL];
  assign ien_v     = cfg_q[spx_pkg::CFG_IEN];
  assign rise_en_v = cfg_q[spx_pkg::CFG_RISE];
  assign fall_en_v = cfg_q[spx_pkg::CFG_FALL];
  assign mask_v    = cfg_q[spx_pkg::CFG_MASK];
  assign lvl       = pins_s ^ pol_v;

  function automatic logic [15:0] rd_mux(input logic [5:0] idx);
    logic [5:0] rel;
    rel    = 6'(idx - spx_pkg::OFF_OUT[7:2]);
    rd_mux = 16'h0000;
    if (idx == spx_pkg::OFF_INPUT[7:2]) begin
      rd_mux = lvl;
    end else if (idx == spx_pkg::OFF_PEND[7:2]) begin
      rd_mux = pend_q;
    end else if (rel < 6'(spx_pkg::NCFG)) begin
      rd_mux = cfg_q[rel[3:0]];
    end
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] data,
                                         input logic [15:0] bm);
    wmerge = (old & ~bm) | (data & bm);
  endfunction

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  logic        spi_rd;
  logic        spi_wr;
  logic [5:0]  spi_idx;
  logic [15:0] spi_wdata;
  logic [15:0] spi_rdata;

  always_comb spi_rdata = rd_mux(spi_idx);

  spx_spi_slave u_link (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (sreset),
    .sclk_s   (sclk_s),
    .csn_s    (csn_s),
    .si_s     (si_s),
    .so       (spi_so),
    .so_oe_n  (spi_so_oe_n),
    .rdata    (spi_rdata),
    .rd_stb   (spi_rd),
    .wr_stb   (spi_wr),
    .idx      (spi_idx),
    .wdata    (spi_wdata)
  );

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  // one wait state: read data captured at the first edge, write lands at the second
  logic        avs_ack_q;
  logic        avs_req;
  logic        avs_rd;
  logic        avs_wr;
  logic [5:0]  avs_idx;
  logic [15:0] avs_bm;

  assign avs_req         = avs_read | avs_write;
  assign avs_waitrequest = avs_req & ~avs_ack_q;
  assign avs_rd          = avs_read & ~avs_ack_q;
  assign avs_wr          = avs_write & avs_ack_q;
  assign avs_idx         = avs_address[7:2];
  assign avs_bm          = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_ack_q    <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      avs_ack_q <= avs_waitrequest;
      if (avs_rd) begin
        avs_readdata <= {16'h0000, rd_mux(avs_idx)};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // a link write and a bus write in one cycle both land; the bus bytes win
  for (genvar k = 0; k < spx_pkg::NCFG; k++) begin : g_cfg
    localparam logic [5:0] KIDX = 6'(spx_pkg::OFF_OUT[7:2] + k);
    logic        hit_spi;
    logic        hit_avs;
    logic [15:0] mid;

    assign hit_spi = spi_wr && spi_idx == KIDX;
    assign hit_avs = avs_wr && avs_idx == KIDX;
    assign mid     = hit_spi ? spi_wdata : cfg_q[k];

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cfg_q[k] <= spx_pkg::CFG_RST[k];
      end else if (ce) begin
        if (sreset) begin
          cfg_q[k] <= spx_pkg::CFG_RST[k];
        end else if (hit_avs) begin
          cfg_q[k] <= wmerge(mid, avs_writedata[15:0], avs_bm);
        end else if (hit_spi) begin
          cfg_q[k] <= spi_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  assign port_pins_o = out_v;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_pins_oe_n      <= 16'hFFFF;
      port_pins_pullup_en <= 16'h0000;
    end else if (ce) begin
      if (sreset) begin
        port_pins_oe_n      <= 16'hFFFF;
        port_pins_pullup_en <= 16'h0000;
      end else begin
        port_pins_oe_n      <= ~(dir_v & ~tri_v);
        port_pins_pullup_en <= pull_v & ~dir_v;
      end
    end
  end

  // ----------------------------------------------------------------
  // change detection and pending flags
  // ----------------------------------------------------------------
  // a polarity write flips the level and may itself count as an edge
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] w1c_v;
  logic        rd_clr;

  assign rd_clr = (spi_rd && spi_idx == spx_pkg::OFF_INPUT[7:2]) ||
                  (avs_rd && avs_idx == spx_pkg::OFF_INPUT[7:2]);
  assign w1c_v  = ((avs_wr && avs_idx == spx_pkg::OFF_PEND[7:2]) ?
                   (avs_writedata[15:0] & avs_bm) : 16'h0000) |
                  ((spi_wr && spi_idx == spx_pkg::OFF_PEND[7:2]) ? spi_wdata : 16'h0000);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 16'h0000;
    end else if (ce) begin
      prev_q <= lvl;
    end
  end

  for (genvar i = 0; i < spx_pkg::PINS; i++) begin : g_pin
    logic up;
    logic down;

    assign up       = lvl[i] & ~prev_q[i];
    assign down     = ~lvl[i] & prev_q[i];
    assign set_v[i] = ien_v[i] & ~dir_v[i] &
                      ((up & rise_en_v[i]) | (down & fall_en_v[i]));
    assign clr_v[i] = (pend_q[i] & (lvl[i] == base_q[i])) | rd_clr | w1c_v[i];

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pend_q[i] <= 1'b0;
        base_q[i] <= 1'b0;
      end else if (ce) begin
        if (sreset) begin
          pend_q[i] <= 1'b0;
        end else if (set_v[i]) begin
          pend_q[i] <= 1'b1;
          base_q[i] <= prev_q[i];
        end else if (clr_v[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  assign irq_n_o = 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_n_oe_n <= 1'b1;
    end else if (ce) begin
      irq_n_oe_n <= ~|(pend_q & mask_v);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_bus_answer;
    (ce && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_pin_drive;
    (ce && !sreset) |=> port_pins_oe_n == ~$past(dir_v & ~tri_v);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong");

  property p_pullup;
    (ce && !sreset) |=> port_pins_pullup_en == $past(pull_v & ~dir_v);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");

  property p_polarity;
    (ce && avs_rd && avs_idx == spx_pkg::OFF_INPUT[7:2])
      |=> avs_readdata[15:0] == $past(pins_s ^ pol_v);
  endproperty
  a_polarity: assert property (p_polarity) else $error("input level wrong");

  property p_edge_set;
    (ce && !sreset && |set_v) |=> (pend_q & $past(set_v)) == $past(set_v);
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not caught");

  property p_auto_clear;
    (ce && !sreset) |=> (pend_q & $past(pend_q & ~(lvl ^ base_q) & ~set_v)) == 16'h0000;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("no auto clear");

  property p_read_clear;
    (ce && rd_clr) |=> (pend_q & ~$past(set_v)) == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("no clear on read");

  property p_irq_pin;
    ce |=> irq_n_o == 1'b0 && irq_n_oe_n == ~|($past(pend_q & mask_v));
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

  property p_reset_pin;
    (ce && !prst_n_s) [*6] |=> sreset;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");

  property p_reset_inputs;
    (ce && sreset) |=> port_pins_oe_n == 16'hFFFF && dir_v == 16'h0000 && pend_q == 16'h0000;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs");

  property p_disabled;
    ce |=> ((pend_q & ~$past(pend_q)) & ~$past(ien_v & ~dir_v)) == 16'h0000;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin pending");

  c_bus_write: cover property (avs_wr);
  c_link_write: cover property (spi_wr);
  c_link_read: cover property (spi_rd ##[1:300] csn_s);
  c_irq: cover property ($fell(irq_n_oe_n));
  c_pin_reset: cover property ($rose(sreset));

endmodule

/* File: hdl/spx_pkg.sv */
// constants, register map and types of the sixteen-pin serial io expander
package spx_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned PINS         = 16;
  localparam int unsigned CLK_NS       = 8;
  localparam int unsigned RST_LOW_NS   = 40;
  // one sample past the limit, so a pulse of exactly the limit is ignored
  localparam logic [3:0]  RST_LOW_CNT  = 4'(RST_LOW_NS / CLK_NS + 1);
  localparam int unsigned SCLK_MAX_KHZ = 26000;
  // sync order: reset pin, chip select, serial clock, serial in, port pins
  localparam logic [19:0] SYNC_RST     = 20'hC0000;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INPUT = 8'h00;
  localparam logic [7:0] OFF_OUT   = 8'h04;
  localparam logic [7:0] OFF_DIR   = 8'h08;
  localparam logic [7:0] OFF_TRI   = 8'h0C;
  localparam logic [7:0] OFF_PULL  = 8'h10;
  localparam logic [7:0] OFF_POL   = 8'h14;
  localparam logic [7:0] OFF_IEN   = 8'h18;
  localparam logic [7:0] OFF_RISE  = 8'h1C;
  localparam logic [7:0] OFF_FALL  = 8'h20;
  localparam logic [7:0] OFF_MASK  = 8'h24;
  localparam logic [7:0] OFF_PEND  = 8'h28;

  // configuration words are stored in one array, offset order
  localparam int unsigned CFG_OUT  = (OFF_OUT - OFF_OUT) / 4;
  localparam int unsigned CFG_DIR  = (OFF_DIR - OFF_OUT) / 4;
  localparam int unsigned CFG_TRI  = (OFF_TRI - OFF_OUT) / 4;
  localparam int unsigned CFG_PULL = (OFF_PULL - OFF_OUT) / 4;
  localparam int unsigned CFG_POL  = (OFF_POL - OFF_OUT) / 4;
  localparam int unsigned CFG_IEN  = (OFF_IEN - OFF_OUT) / 4;
  localparam int unsigned CFG_RISE = (OFF_RISE - OFF_OUT) / 4;
  localparam int unsigned CFG_FALL = (OFF_FALL - OFF_OUT) / 4;
  localparam int unsigned CFG_MASK = (OFF_MASK - OFF_OUT) / 4;
  localparam int unsigned NCFG     = CFG_MASK + 1;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [NCFG-1:0][15:0] CFG_RST = {RST_MASK, {(NCFG - 1){RST_ZERO}}};

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_RD   = 2'b01,
    PH_WR   = 2'b10,
    PH_DONE = 2'b11
  } spx_phase_t;

endpackage

/* File: hdl/spx_spi_slave.sv */
// serial frame engine: command byte then sixteen data bits, mode 0
module spx_spi_slave (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        clr,
  // synchronised link
  input  wire logic        sclk_s,
  input  wire logic        csn_s,
  input  wire logic        si_s,
  output logic             so,
  output logic             so_oe_n,
  // register access
  input  wire logic [15:0] rdata,
  output logic             rd_stb,
  output logic             wr_stb,
  output logic [5:0]       idx,
  output logic [15:0]      wdata
);

  logic                sclk_p_q;
  logic [4:0]          cnt_q;
  logic [15:0]         sh_q;
  logic [15:0]         tx_q;
  spx_pkg::spx_phase_t ph_q;
  logic                rise;
  logic                fall;

  assign rise = sclk_s & ~sclk_p_q;
  assign fall = ~sclk_s & sclk_p_q;
  assign so   = tx_q[15];

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_p_q <= 1'b0;
      cnt_q    <= 5'h00;
      sh_q     <= 16'h0000;
      ph_q     <= spx_pkg::PH_CMD;
      rd_stb   <= 1'b0;
      wr_stb   <= 1'b0;
      idx      <= 6'h00;
      wdata    <= 16'h0000;
    end else if (ce) begin
      sclk_p_q <= sclk_s;
      rd_stb   <= 1'b0;
      wr_stb   <= 1'b0;
      if (clr || csn_s) begin
        cnt_q <= 5'h00;
        ph_q  <= spx_pkg::PH_CMD;
      end else if (rise && ph_q != spx_pkg::PH_DONE) begin
        sh_q  <= {sh_q[14:0], si_s};
        cnt_q <= cnt_q + 5'h01;
        unique case (ph_q)
          spx_pkg::PH_CMD: begin
            if (cnt_q == spx_pkg::CMD_BITS - 5'h01) begin
              idx    <= {sh_q[4:0], si_s};
              ph_q   <= sh_q[6] ? spx_pkg::PH_RD : spx_pkg::PH_WR;
              rd_stb <= sh_q[6];
            end
          end
          spx_pkg::PH_WR: begin
            if (cnt_q == spx_pkg::FRAME_BITS - 5'h01) begin
              wdata  <= {sh_q[14:0], si_s};
              wr_stb <= 1'b1;
              ph_q   <= spx_pkg::PH_DONE;
            end
          end
          spx_pkg::PH_RD: begin
            if (cnt_q == spx_pkg::FRAME_BITS - 5'h01) begin
              ph_q <= spx_pkg::PH_DONE;
            end
          end
          spx_pkg::PH_DONE: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // serial out, changes on falling edges after the first data bit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_q    <= 16'h0000;
      so_oe_n <= 1'b1;
    end else if (ce) begin
      so_oe_n <= csn_s;
      if (rd_stb) begin
        tx_q <= rdata;
      end else if (fall && ph_q == spx_pkg::PH_RD && cnt_q > spx_pkg::CMD_BITS) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_so_released;
    @(posedge core_clk) disable iff (rst) (ce && csn_s) |=> so_oe_n;
  endproperty
  a_so_released: assert property (p_so_released) else $error("serial out driven while idle");

endmodule

/* File: bench/spx_host_model.sv */
// serial host model: frames the link, makes its clock, shifts data both ways
module spx_host_model (
  // link to the expander
  output logic       spi_sclk,
  output logic       spi_cs_n,
  output logic       spi_si,
  input  wire logic  spi_so,
  input  wire logic  spi_so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock stands low outside frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // one framed transfer: command byte, then sixteen data bits, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] f;
    f = {cmd, wd};
    rd = 16'h0000;
    spi_cs_n = 1'b0;
    #40;
    for (int i = 23; i >= 0; i--) begin
      spi_si = f[i];
      // 64 ns period keeps the link well under its top rate
      #32 spi_sclk = 1'b1;
      if (i < 16) begin
        // a released line reads as the inverse, so an undriven bit shows up
        rd = {rd[14:0], spi_so_oe_n ? ~spi_so : spi_so};
      end
      #32 spi_sclk = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    // released data line must not keep a stale level
    spi_si = ~spi_si;
    #40;
  endtask
endmodule

/* File: bench/spi_sixteen_pin_io_expander_test.sv */
// bench top: drives the expander over the register bus, the link and the pins
module spi_sixteen_pin_io_expander_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        core_clk, rst, ce, avs_read, avs_write, avs_waitrequest, pin_reset_n;
  logic        spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe_n, irq_n_o, irq_n_oe_n;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] port_pins_i, port_pins_o, port_pins_oe_n, port_pins_pullup_en, q;
  int          n_mismatch, check_count;

  spx_expander dut_u (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .spi_sclk,
    .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n, .pin_reset_n, .port_pins_i,
    .port_pins_o, .port_pins_oe_n, .port_pins_pullup_en, .irq_n_o, .irq_n_oe_n);
  spx_host_model host_u (.spi_sclk, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n);

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // entered just after a rising edge; idle cycles after it let launched outputs settle
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      test_done();
    end
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic lk(input logic rd, input logic [7:0] a, input logic [15:0] d);
    host_u.xfer({rd, 1'b0, a[7:2]}, d, q);
    @(posedge core_clk);
  endtask

  task automatic pin(input logic [15:0] v);
    port_pins_i <= v;
    repeat (8) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("oe_n", 16'hFFFF, port_pins_oe_n);
    chk("pullup", 16'h0000, port_pins_pullup_en);
    chk("irq oe", 16'h0001, {15'h0000, irq_n_oe_n});
    chk("so oe", 16'h0001, {15'h0000, spi_so_oe_n});
    bus(1'b0, spx_pkg::OFF_MASK, 16'h0000);
    chk("mask", 16'hFFFF, q);
    bus(1'b1, 8'hFC, 16'h1234);
    bus(1'b0, 8'hFC, 16'h0000);
    chk("unmapped", 16'h0000, q);
    $display("test reset done");
  endtask

  task automatic t_out();
    bus(1'b1, spx_pkg::OFF_DIR, 16'hFF0F);
    bus(1'b1, spx_pkg::OFF_OUT, 16'hA5C3);
    bus(1'b1, spx_pkg::OFF_TRI, 16'h0F30);
    bus(1'b1, spx_pkg::OFF_PULL, 16'h00FF);
    chk("out", 16'hA5C3, port_pins_o);
    chk("oe_n", 16'h0FF0, port_pins_oe_n);
    chk("pullup", 16'h00F0, port_pins_pullup_en);
    avs_byteenable <= 4'h1;
    bus(1'b1, spx_pkg::OFF_OUT, 16'hFFFF);
    avs_byteenable <= 4'hF;
    chk("lane", 16'hA5FF, port_pins_o);
    $display("test outputs done");
  endtask

  task automatic t_in();
    pin(16'h1234);
    lk(1'b0, spx_pkg::OFF_DIR, 16'h0000);
    lk(1'b0, spx_pkg::OFF_POL, 16'h00FF);
    chk("oe_n", 16'hFFFF, port_pins_oe_n);
    bus(1'b0, spx_pkg::OFF_INPUT, 16'h0000);
    chk("bus in", 16'h12CB, q);
    lk(1'b1, spx_pkg::OFF_INPUT, 16'h0000);
    chk("link in", 16'h12CB, q);
    chk("so oe", 16'h0001, {15'h0000, spi_so_oe_n});
    $display("test inputs done");
  endtask

  task automatic t_irq();
    bus(1'b1, spx_pkg::OFF_POL, 16'h0000);
    pin(16'h0000);
    bus(1'b1, spx_pkg::OFF_PEND, 16'hFFFF);
    bus(1'b1, spx_pkg::OFF_IEN, 16'h0001);
    bus(1'b1, spx_pkg::OFF_RISE, 16'h0001);
    pin(16'h0001);
    chk("rise", 16'h0000, {15'h0000, irq_n_oe_n});
    chk("irq lvl", 16'h0000, {15'h0000, irq_n_o});
    pin(16'h0000);
    chk("auto clr", 16'h0001, {15'h0000, irq_n_oe_n});
    bus(1'b1, spx_pkg::OFF_RISE, 16'h0000);
    bus(1'b1, spx_pkg::OFF_FALL, 16'h0001);
    pin(16'h0001);
    chk("no rise", 16'h0001, {15'h0000, irq_n_oe_n});
    pin(16'h0000);
    chk("fall", 16'h0000, {15'h0000, irq_n_oe_n});
    bus(1'b0, spx_pkg::OFF_INPUT, 16'h0000);
    chk("read clr", 16'h0001, {15'h0000, irq_n_oe_n});
    bus(1'b1, spx_pkg::OFF_RISE, 16'h0001);
    pin(16'h0001);
    chk("both", 16'h0000, {15'h0000, irq_n_oe_n});
    bus(1'b1, spx_pkg::OFF_PEND, 16'h0001);
    chk("w1c", 16'h0001, {15'h0000, irq_n_oe_n});
    bus(1'b1, spx_pkg::OFF_MASK, 16'h0000);
    pin(16'h0000);
    bus(1'b0, spx_pkg::OFF_PEND, 16'h0000);
    chk("pend", 16'h0001, q);
    chk("masked", 16'h0001, {15'h0000, irq_n_oe_n});
    bus(1'b1, spx_pkg::OFF_PEND, 16'h0001);
    bus(1'b1, spx_pkg::OFF_IEN, 16'h0000);
    bus(1'b1, spx_pkg::OFF_MASK, 16'hFFFF);
    pin(16'h0001);
    bus(1'b0, spx_pkg::OFF_PEND, 16'h0000);
    chk("disabled", 16'h0000, q);
    chk("dis irq", 16'h0001, {15'h0000, irq_n_oe_n});
    $display("test interrupt done");
  endtask

  // five low samples is exactly 40 ns and must be ignored
  task automatic t_rst();
    bus(1'b1, spx_pkg::OFF_DIR, 16'hFFFF);
    pin_reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    pin_reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("short", 16'h0F30, port_pins_oe_n);
    pin_reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    pin_reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("oe_n", 16'hFFFF, port_pins_oe_n);
    bus(1'b0, spx_pkg::OFF_TRI, 16'h0000);
    chk("tri", 16'h0000, q);
    bus(1'b0, spx_pkg::OFF_MASK, 16'h0000);
    chk("mask", 16'hFFFF, q);
    $display("test reset pin done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    core_clk       = 1'b0;
    rst            = 1'b1;
    ce             = 1'b1;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 8'h00;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    pin_reset_n    = 1'b1;
    port_pins_i    = 16'h0000;
    n_mismatch     = 0;
    check_count    = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_out();
    t_in();
    t_irq();
    t_rst();
    test_done();
  end
endmodule
